/* File: frc_pkg.sv */
// Purpose: Shared constants and types for the fault retry and delay block
// Assumes: Registers are addressed by their PMBus command code
// Notes: Time units are counted in 1 ms ticks of the 100 MHz clock
package frc_pkg;
    // Command codes
    localparam logic [7:0] CMD_RESPONSE = 8'hba;
    localparam logic [7:0] CMD_STARTUP_LIMIT = 8'hbb;
    localparam logic [7:0] CMD_SC_LIMIT = 8'hbc;
    localparam logic [7:0] CMD_SRC_SELECT = 8'hbd;
    localparam logic [7:0] CMD_TIME_UNITS = 8'hc8;
    // Fields of the response and source select registers
    localparam int RESP_LO = 6;
    localparam int RETRY_LO = 3;
    localparam int DELAY_LO = 0;
    localparam int SRC_BIT = 0;
    // Reset values
    localparam logic [7:0] RST_RESPONSE = 8'hc0;
    localparam logic [7:0] RST_STARTUP_LIMIT = 8'h00;
    localparam logic [7:0] RST_SC_LIMIT = 8'h00;
    localparam logic [7:0] RST_SRC_SELECT = 8'h01;
    localparam logic [7:0] RST_TIME_UNITS = 8'h00;
    // Response and retry codes
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_LIMIT = 2'h2;
    localparam logic [1:0] RESP_SHUTDOWN = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    // Time unit per two-bit code, in ms ticks
    localparam logic [15:0] UNIT_MS_0 = 16'h0001;
    localparam logic [15:0] UNIT_MS_1 = 16'h0004;
    localparam logic [15:0] UNIT_MS_2 = 16'h0010;
    localparam logic [15:0] UNIT_MS_3 = 16'h0100;
    // Tick timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 1;
    localparam int NS_PER_MS = 1000000;
    localparam int TICK_CYC = TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int PRESC_W = 24;
    localparam int DLY_W = 16;
    typedef enum logic [2:0] {
        ST_OFF, ST_RUN, ST_HOLD, ST_WAIT, ST_RESTART, ST_LATCH
    } frc_state_e;
endpackage

/* File: frc_fault_retry.sv */
// Purpose: Fault response, restart counting and delay timing for the converter
// Assumes: All inputs are synchronous to CLOCK; registers by command code
// Notes: Read data is registered, so it follows CMD_CODE one cycle later
`timescale 1ns/1ps
`default_nettype none
module frc_fault_retry #(
    parameter int TICK_CYCLES = frc_pkg::TICK_CYC
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic CMD_WR,
    input wire logic [7:0] CMD_CODE,
    input wire logic [7:0] CMD_WDATA,
    output logic [7:0] CMD_RDATA,
    input wire logic ON_CMD,
    input wire logic FAULT_DET,
    input wire logic [1:0] FAULT_CLASS,
    input wire logic IN_LIMIT,
    input wire logic RESTART_OK,
    input wire logic SHUTDOWN_FAULT,
    input wire logic FAULT_CLEAR,
    output logic OUTPUT_EN,
    output logic FAULT_FLAG,
    output logic NOTIFY,
    output logic [2:0] RETRY_COUNT,
    output logic [7:0] ACTIVE_SC_LIMIT,
    output logic USE_VOUT_CMD
);
    typedef struct packed {
        frc_pkg::frc_state_e state;
        logic [7:0] response;
        logic [7:0] startup_limit;
        logic [7:0] sc_limit;
        logic [7:0] src_select;
        logic [7:0] time_units;
        logic [1:0] cls;
        logic [2:0] cnt;
        logic [frc_pkg::PRESC_W-1:0] presc;
        logic [frc_pkg::DLY_W-1:0] dly;
        logic en;
        logic flag;
        logic notify;
        logic [7:0] rdata;
        logic [7:0] active_limit;
    } frc_regs_s;

    localparam logic [frc_pkg::PRESC_W-1:0] PRESC_LAST = frc_pkg::PRESC_W'(TICK_CYCLES - 1);

    frc_regs_s r_q;
    frc_regs_s r_d;

    function automatic logic [15:0] unit_ms(input logic [1:0] code);
        case (code)
            2'h0: unit_ms = frc_pkg::UNIT_MS_0;
            2'h1: unit_ms = frc_pkg::UNIT_MS_1;
            2'h2: unit_ms = frc_pkg::UNIT_MS_2;
            default: unit_ms = frc_pkg::UNIT_MS_3;
        endcase
    endfunction

    function automatic logic [15:0] delay_ticks(input logic [7:0] units, input logic [1:0] cls,
                                                input logic [2:0] n);
        logic [7:0] sh;
        // class picks the field; temperature is class 0
        sh = units >> {cls, 1'b0};
        delay_ticks = unit_ms(sh[1:0]) << n;
    endfunction

    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] dfield;
    logic tick;
    logic expired;
    assign resp = r_q.response[frc_pkg::RESP_LO +: 2];
    assign retry = r_q.response[frc_pkg::RETRY_LO +: 3];
    assign dfield = r_q.response[frc_pkg::DELAY_LO +: 3];
    assign tick = (r_q.presc == PRESC_LAST);
    assign expired = (r_q.dly == '0);

    always_comb begin
        logic go_down;
        logic fault_evt;
        logic [1:0] cls_now;
        go_down = 1'b0;
        fault_evt = 1'b0;
        cls_now = r_q.cls;
        r_d = r_q;
        r_d.notify = 1'b0;
        r_d.presc = tick ? '0 : r_q.presc + 1'b1;
        if (tick && !expired) begin
            r_d.dly = r_q.dly - 1'b1;
        end
        // response; startup limit; run limit; source select; unit register
        if (CMD_WR) begin
            case (CMD_CODE)
                frc_pkg::CMD_RESPONSE: r_d.response = CMD_WDATA;
                frc_pkg::CMD_STARTUP_LIMIT: r_d.startup_limit = CMD_WDATA;
                frc_pkg::CMD_SC_LIMIT: r_d.sc_limit = CMD_WDATA;
                frc_pkg::CMD_SRC_SELECT: r_d.src_select = CMD_WDATA;
                frc_pkg::CMD_TIME_UNITS: r_d.time_units = CMD_WDATA;
                default: r_d.rdata = r_q.rdata;
            endcase
        end
        case (CMD_CODE)
            frc_pkg::CMD_RESPONSE: r_d.rdata = r_q.response;
            frc_pkg::CMD_STARTUP_LIMIT: r_d.rdata = r_q.startup_limit;
            frc_pkg::CMD_SC_LIMIT: r_d.rdata = r_q.sc_limit;
            frc_pkg::CMD_SRC_SELECT: r_d.rdata = {7'h00, r_q.src_select[frc_pkg::SRC_BIT]};
            frc_pkg::CMD_TIME_UNITS: r_d.rdata = r_q.time_units;
            default: r_d.rdata = 8'h00;
        endcase
        case (r_q.state)
            frc_pkg::ST_OFF: begin
                if (ON_CMD) begin
                    r_d.state = frc_pkg::ST_RESTART;
                end
            end
            frc_pkg::ST_RUN: begin
                if (FAULT_DET) begin
                    fault_evt = 1'b1;
                    cls_now = FAULT_CLASS;
                    r_d.cls = FAULT_CLASS;
                    if (resp == frc_pkg::RESP_SHUTDOWN) begin
                        go_down = 1'b1;
                    end else if (resp != frc_pkg::RESP_IGNORE) begin
                        r_d.state = frc_pkg::ST_HOLD;
                        r_d.dly = delay_ticks(r_q.time_units, FAULT_CLASS, dfield);
                        r_d.presc = '0;
                    end
                end
            end
            frc_pkg::ST_HOLD: begin
                if (expired) begin
                    if (resp == frc_pkg::RESP_LIMIT && !IN_LIMIT) begin
                        r_d.state = frc_pkg::ST_RUN;
                    end else begin
                        go_down = 1'b1;
                    end
                end
            end
            frc_pkg::ST_WAIT: begin
                if (expired) begin
                    r_d.state = frc_pkg::ST_RESTART;
                    if (r_q.cnt != frc_pkg::RETRY_FOREVER - 3'h1) begin
                        r_d.cnt = r_q.cnt + 3'h1;
                    end
                end
            end
            frc_pkg::ST_RESTART: begin
                if (FAULT_DET) begin
                    fault_evt = 1'b1;
                    // A failed attempt brings its own class, so the next gap uses its unit
                    cls_now = FAULT_CLASS;
                    r_d.cls = FAULT_CLASS;
                    go_down = 1'b1;
                end else if (RESTART_OK) begin
                    r_d.state = frc_pkg::ST_RUN;
                end
            end
            frc_pkg::ST_LATCH: begin
                if (FAULT_CLEAR) begin
                    r_d.state = frc_pkg::ST_OFF;
                end
            end
            default: r_d.state = frc_pkg::ST_OFF;
        endcase
        if (go_down) begin
            // no retry; count limit; latch off; forever
            if (retry == frc_pkg::RETRY_NONE ||
                (retry != frc_pkg::RETRY_FOREVER && r_q.cnt >= retry)) begin
                r_d.state = frc_pkg::ST_LATCH;
            end else begin
                r_d.state = frc_pkg::ST_WAIT;
                r_d.dly = delay_ticks(r_q.time_units, cls_now, dfield);
                r_d.presc = '0;
            end
        end
        if (SHUTDOWN_FAULT && r_q.state != frc_pkg::ST_OFF) begin
            r_d.state = frc_pkg::ST_LATCH;
            fault_evt = 1'b1;
        end
        // fresh sequence after clear or off
        if (FAULT_CLEAR || !ON_CMD) begin
            r_d.cnt = 3'h0;
        end
        if (!ON_CMD) begin
            r_d.state = frc_pkg::ST_OFF;
            r_d.dly = '0;
        end
        r_d.flag = (r_q.flag && !FAULT_CLEAR) || fault_evt;
        r_d.notify = fault_evt;
        r_d.en = (r_d.state == frc_pkg::ST_RUN) || (r_d.state == frc_pkg::ST_HOLD) ||
                 (r_d.state == frc_pkg::ST_RESTART);
        // Startup limit only while bringing the output up
        r_d.active_limit = (r_d.state == frc_pkg::ST_RESTART) ? r_d.startup_limit : r_d.sc_limit;
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            r_q <= '0;
            r_q.state <= frc_pkg::ST_OFF;
            r_q.response <= frc_pkg::RST_RESPONSE;
            r_q.startup_limit <= frc_pkg::RST_STARTUP_LIMIT;
            r_q.sc_limit <= frc_pkg::RST_SC_LIMIT;
            r_q.src_select <= frc_pkg::RST_SRC_SELECT;
            r_q.time_units <= frc_pkg::RST_TIME_UNITS;
            r_q.active_limit <= frc_pkg::RST_SC_LIMIT;
        end else begin
            r_q <= r_d;
        end
    end

    assign CMD_RDATA = r_q.rdata;
    assign OUTPUT_EN = r_q.en;
    assign FAULT_FLAG = r_q.flag;
    assign NOTIFY = r_q.notify;
    assign RETRY_COUNT = r_q.cnt;
    assign ACTIVE_SC_LIMIT = r_q.active_limit;
    assign USE_VOUT_CMD = r_q.src_select[frc_pkg::SRC_BIT];

    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);

    a_limit_latch: assert property (
        (r_q.state == frc_pkg::ST_RESTART && FAULT_DET && ON_CMD && !SHUTDOWN_FAULT &&
         retry != frc_pkg::RETRY_FOREVER && retry != 3'h0 && r_q.cnt >= retry)
        |=> r_q.state == frc_pkg::ST_LATCH && !OUTPUT_EN)
        else $error("retry limit not latched");
    a_latch_holds: assert property (
        (r_q.state == frc_pkg::ST_LATCH && !FAULT_CLEAR) |=> !OUTPUT_EN)
        else $error("output on while latched");
    a_forever_retry: assert property (
        (r_q.state == frc_pkg::ST_RESTART && FAULT_DET && ON_CMD && !SHUTDOWN_FAULT &&
         retry == frc_pkg::RETRY_FOREVER) |=> r_q.state == frc_pkg::ST_WAIT)
        else $error("continuous retry stopped");
    a_delay_load: assert property (
        ($changed(r_q.state) && r_q.state == frc_pkg::ST_WAIT)
        |-> r_q.dly == (unit_ms(2'(r_q.time_units >> {r_q.cls, 1'b0})) << $past(dfield)))
        else $error("delay count wrong");
    a_delay_tick: assert property (
        (r_q.state == frc_pkg::ST_WAIT && !tick && !expired && ON_CMD && !SHUTDOWN_FAULT)
        |=> $stable(r_q.dly))
        else $error("delay moved without tick");
    a_no_retry: assert property (
        (r_q.state == frc_pkg::ST_RUN && FAULT_DET && ON_CMD &&
         resp == frc_pkg::RESP_SHUTDOWN && retry == frc_pkg::RETRY_NONE)
        |=> r_q.state == frc_pkg::ST_LATCH)
        else $error("restart with retry code zero");
    a_flag_notify: assert property (
        (r_q.state == frc_pkg::ST_RUN && FAULT_DET && ON_CMD) |=> FAULT_FLAG && NOTIFY)
        else $error("fault not flagged");
    a_limit_resume: assert property (
        (r_q.state == frc_pkg::ST_HOLD && expired && resp == frc_pkg::RESP_LIMIT && !IN_LIMIT &&
         ON_CMD && !SHUTDOWN_FAULT) |=> r_q.state == frc_pkg::ST_RUN)
        else $error("limit response mishandled");
    a_sc_write: assert property (
        (CMD_WR && CMD_CODE == frc_pkg::CMD_SC_LIMIT) ##1 (CMD_CODE == frc_pkg::CMD_SC_LIMIT)
        |=> CMD_RDATA == $past(CMD_WDATA, 2))
        else $error("run limit readback wrong");
    a_off_reset: assert property (
        !ON_CMD |=> RETRY_COUNT == 3'h0 && !OUTPUT_EN)
        else $error("off did not reset retries");
    a_gap_step: assert property (
        (r_q.state == frc_pkg::ST_WAIT && tick && !expired && ON_CMD && !SHUTDOWN_FAULT)
        |=> r_q.dly == $past(r_q.dly) - 1'b1)
        else $error("delay did not step on tick");
    a_start_limit: assert property (
        (r_q.state == frc_pkg::ST_RESTART) |-> ACTIVE_SC_LIMIT == r_q.startup_limit)
        else $error("startup limit not applied");
    a_src_follow: assert property (
        (CMD_WR && CMD_CODE == frc_pkg::CMD_SRC_SELECT)
        |=> USE_VOUT_CMD == $past(CMD_WDATA[frc_pkg::SRC_BIT]))
        else $error("setpoint source not updated");

    c_retry_wait: cover property (r_q.state == frc_pkg::ST_WAIT ##1
        r_q.state == frc_pkg::ST_RESTART);
    c_endless: cover property (retry == frc_pkg::RETRY_FOREVER && r_q.state == frc_pkg::ST_WAIT);
    c_latched: cover property (r_q.state == frc_pkg::ST_LATCH);
    c_hold_resume: cover property (r_q.state == frc_pkg::ST_HOLD ##1 r_q.state == frc_pkg::ST_RUN);
endmodule
`default_nettype wire

/* File: frc_stage_model.sv */
// Purpose: Behavioural power stage that answers each restart attempt
// Assumes: An attempt begins when OUTPUT_EN rises; driven at the falling edge
// Notes: A failed attempt shows as a single fault cycle while still restarting
`timescale 1ns/1ps
`default_nettype none
module frc_stage_model (
    input wire logic clk,
    input wire logic load,
    input wire logic [3:0] fails,
    input wire logic [3:0] lat,
    input wire logic output_en,
    output logic restart_ok,
    output logic fail_det
);
    logic [3:0] left_q = 4'h0;
    logic [7:0] age_q = 8'h00;
    initial begin
        restart_ok = 1'b0;
        fail_det = 1'b0;
    end
    always @(negedge clk) begin
        restart_ok <= 1'b0;
        fail_det <= 1'b0;
        // Age saturates so a long run is never judged a second time
        if (!output_en) begin
            age_q <= 8'h00;
        end else if (age_q != 8'hff) begin
            age_q <= age_q + 8'h01;
        end
        if (load) begin
            left_q <= fails;
        end else if (output_en && age_q == {4'h0, lat}) begin
            if (left_q != 4'h0) begin
                left_q <= left_q - 4'h1;
                fail_det <= 1'b1;
            end else begin
                restart_ok <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test_fault_retry_delay_control.sv */
// Purpose: Self-checking bench for the fault retry and delay block
// Assumes: A tick of 4 clocks stands for one millisecond
// Notes: Delay gaps get one tick of slack; the prescaler restarts from zero when a delay loads
`timescale 1ns/1ps
`default_nettype none
`define FRC_CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module test_fault_retry_delay_control;
    localparam int TICK = 4;
    logic clk = 1'b0, rst = 1'b1, cmd_wr = 1'b0, on_cmd = 1'b0, tb_fault = 1'b0;
    logic in_limit = 1'b0, sd_fault = 1'b0, fault_clear = 1'b0, model_load = 1'b0;
    logic [7:0] cmd_code = 8'h00, cmd_wdata = 8'h00, cmd_rdata, act_lim, rd_val;
    logic [7:0] lim_start, lim_run, units;
    logic [3:0] model_fails = 4'h0, model_lat = 4'h1;
    logic [2:0] retry_cnt;
    logic [1:0] fault_class = 2'h0;
    logic out_en, fault_flag, notify, use_vout, restart_ok, model_fail, en_prev = 1'b0;
    logic gap_ok;
    logic [2:0] codes [5] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
    logic [1:0] rsps [4] = '{2'h0, 2'h2, 2'h2, 2'h1};
    int fail_count = 0, num_checks = 0, rises = 0, low_cnt = 0, notifies = 0;
    int gap_lo = 0, gap_hi = 0, n;
    frc_fault_retry #(.TICK_CYCLES(TICK)) uut (
        .CLOCK(clk), .RESET(rst), .CMD_WR(cmd_wr), .CMD_CODE(cmd_code),
        .CMD_WDATA(cmd_wdata), .CMD_RDATA(cmd_rdata), .ON_CMD(on_cmd),
        .FAULT_DET(tb_fault | model_fail), .FAULT_CLASS(fault_class), .IN_LIMIT(in_limit),
        .RESTART_OK(restart_ok), .SHUTDOWN_FAULT(sd_fault), .FAULT_CLEAR(fault_clear),
        .OUTPUT_EN(out_en), .FAULT_FLAG(fault_flag), .NOTIFY(notify),
        .RETRY_COUNT(retry_cnt), .ACTIVE_SC_LIMIT(act_lim), .USE_VOUT_CMD(use_vout));
    frc_stage_model stage (.clk(clk), .load(model_load), .fails(model_fails),
        .lat(model_lat), .output_en(out_en), .restart_ok(restart_ok), .fail_det(model_fail));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic finish_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Longest run is about 40k cycles, so 95k cycles means a hang
    initial begin
        #950000;
        fail_count++;
        finish_test();
    end
    always @(negedge clk) begin
        if (notify === 1'b1) notifies++;
        if (out_en === 1'b1 && en_prev !== 1'b1) begin
            `FRC_CHK("startup limit active", lim_start, act_lim)
            if (rises > 0) begin
                gap_ok = 1'(low_cnt >= gap_lo && low_cnt <= gap_hi);
                `FRC_CHK("retry gap", 1'b1, gap_ok)
            end
            rises++;
        end
        low_cnt = (out_en === 1'b1) ? 0 : low_cnt + 1;
        en_prev = out_en;
    end
    function automatic int unit_ms(input logic [1:0] c);
        return (c == 2'h0) ? 1 : (c == 2'h1) ? 4 : (c == 2'h2) ? 16 : 256;
    endfunction
    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        cmd_wr = 1'b1;
        cmd_code = code;
        cmd_wdata = data;
        @(negedge clk);
        cmd_wr = 1'b0;
        // Let an edge pass so back-to-back writes never touch the strobe twice at once
        @(negedge clk);
    endtask
    task automatic reg_chk(input string nm, input logic [7:0] code, input logic [7:0] e);
        cmd_code = code;
        @(negedge clk);
        rd_val = cmd_rdata;
        `FRC_CHK(nm, e, rd_val)
    endtask
    task automatic arm(input logic [1:0] rsp, input logic [2:0] rt, input logic [2:0] dl,
        input logic [1:0] cls, input logic [3:0] nf);
        int u;
        u = unit_ms(units[2 * cls +: 2]);
        // Long units keep a short delay so the run stays bounded
        while (dl != 3'h0 && (1 << dl) * u * TICK > 1100) begin
            dl--;
        end
        gap_lo = (1 << dl) * u * TICK - TICK;
        gap_hi = gap_lo + 2 * TICK + 3;
        fault_class = cls;
        wr(8'hba, {rsp, rt, dl});
        model_fails = nf;
        model_lat = 4'($urandom_range(1, 6));
        // Held over a whole falling edge so the stage model samples it without a race
        model_load = 1'b1;
        repeat (2) @(negedge clk);
        model_load = 1'b0;
        rises = 0;
        on_cmd = 1'b1;
    endtask
    task automatic clear_off();
        on_cmd = 1'b0;
        fault_clear = 1'b1;
        @(negedge clk);
        fault_clear = 1'b0;
        repeat (2) @(negedge clk);
        `FRC_CHK("count after clear", 3'h0, retry_cnt)
        `FRC_CHK("flag after clear", 1'b0, fault_flag)
        `FRC_CHK("output after off", 1'b0, out_en)
    endtask
    initial begin
        void'($urandom(32'hc857));
        repeat (8) @(negedge clk);
        rst = 1'b0;
        `FRC_CHK("source select reset", 1'b1, use_vout)
        for (int i = 0; i < 6; i++) begin
            lim_start = 8'($urandom);
            lim_run = lim_start ^ 8'($urandom_range(1, 255));
            units = 8'($urandom);
            wr(8'hbb, lim_start);
            wr(8'hbc, lim_run);
            wr(8'hbd, units);
            wr(8'hbe, 8'hff);
            reg_chk("startup limit reg", 8'hbb, lim_start);
            reg_chk("run limit reg", 8'hbc, lim_run);
            reg_chk("source select reg", 8'hbd, {7'h00, units[0]});
            `FRC_CHK("source select out", units[0], use_vout)
            reg_chk("unmapped reg", 8'hbe, 8'h00);
        end
        units = 8'he4;
        wr(8'hc8, units);
        reg_chk("time units reg", 8'hc8, units);
        foreach (codes[r]) begin
            arm(2'h3, codes[r], 3'($urandom), 2'(r), 4'hf);
            repeat ((codes[r] + 2) * (gap_hi + 12)) @(negedge clk);
            `FRC_CHK("attempts", codes[r] + 1, rises)
            `FRC_CHK("latched off", 1'b0, out_en)
            `FRC_CHK("retry count", codes[r], retry_cnt)
            `FRC_CHK("flag latched", 1'b1, fault_flag)
            clear_off();
        end
        arm(2'h3, 3'h7, 3'($urandom), 2'($urandom), 4'ha);
        repeat (12 * (gap_hi + 12)) @(negedge clk);
        `FRC_CHK("endless attempts", 11, rises)
        `FRC_CHK("endless recovers", 1'b1, out_en)
        `FRC_CHK("run limit active", lim_run, act_lim)
        sd_fault = 1'b1;
        @(negedge clk);
        sd_fault = 1'b0;
        repeat (2) @(negedge clk);
        `FRC_CHK("other fault stops", 1'b0, out_en)
        clear_off();
        foreach (rsps[k]) begin
            arm(rsps[k], 3'h0, 3'($urandom), 2'($urandom), 4'h0);
            in_limit = 1'(k == 2);
            repeat (20) @(negedge clk);
            notifies = 0;
            tb_fault = 1'b1;
            @(negedge clk);
            tb_fault = 1'b0;
            n = 0;
            while (out_en === 1'b1 && n < gap_hi + 20) begin
                @(negedge clk);
                n++;
            end
            `FRC_CHK("hold outcome", 1'(k >= 2), 1'(n >= gap_lo && n <= gap_hi))
            `FRC_CHK("notify once", 1, notifies)
            `FRC_CHK("flag set", 1'b1, fault_flag)
            clear_off();
        end
        finish_test();
    end
endmodule
`undef FRC_CHK
`default_nettype wire
